// [include/pmes_pkg.sv]
package pmes_pkg;

   // Special register numbers seen by the move-to and move-from port
   localparam logic [9:0] PMES_SPR_SAMPLED_ADDR = 10'h30C;
   localparam logic [9:0] PMES_SPR_EVENT_SEL_1 = 10'h31E;

   // Select fields of monitor_event_select_1, stored little-endian:
   // the register's big-endian bit b lives at position 31 - b
   localparam int PMES_SEL4_LSB = 22;
   localparam int PMES_SEL5_LSB = 17;
   localparam int PMES_SEL6_LSB = 12;
   localparam int PMES_SEL7_LSB = 7;
   localparam int PMES_SEL8_LSB = 3;
   localparam int PMES_SEL_W = 5;
   localparam int PMES_SEL8_W = 4;

   localparam logic [31:0] PMES_EVENT_SEL_RESET = 32'h0000_0000;
   localparam logic [63:0] PMES_SAMPLED_RESET = 64'h0000_0000_0000_0000;

   // Codes that route the chaining input instead of a processor event
   localparam logic [4:0] PMES_CODE_CHAIN = 5'h0F;
   localparam logic [3:0] PMES_CODE8_CHAIN = 4'hF;

   // Named event codes
   localparam logic [4:0] PMES_C4_DISPATCH_EMPTY = 5'h17;
   localparam logic [4:0] PMES_C4_LINK_STACK_ERR = 5'h18;
   localparam logic [4:0] PMES_C4_CR_LOGIC_RESULT = 5'h19;
   localparam logic [4:0] PMES_C4_SNOOP_CLEAN_L1 = 5'h1B;
   localparam logic [4:0] PMES_C5_DATA_XLATE_MISS = 5'h00;
   localparam logic [4:0] PMES_C5_FETCH_BLOCK = 5'h01;
   localparam logic [4:0] PMES_C5_NONE_COMPLETED = 5'h02;
   localparam logic [4:0] PMES_C5_SNOOP_M_TO_I = 5'h0A;
   localparam logic [4:0] PMES_C5_RETRY_IN = 5'h0D;
   localparam logic [4:0] PMES_C6_STORE_HIT_L1 = 5'h01;
   localparam logic [4:0] PMES_C6_EE_OFF_PENDING = 5'h09;
   localparam logic [4:0] PMES_C6_SNOOP_E_TO_S = 5'h0E;
   localparam logic [4:0] PMES_C7_ICACHE_MISS = 5'h00;
   localparam logic [4:0] PMES_C7_BRANCH_CANCEL = 5'h03;
   localparam logic [3:0] PMES_C8_STCX_OK = 4'h3;
   localparam logic [3:0] PMES_C8_RETRY_OUT = 4'h5;

endpackage

// [core/pmes_top.sv]
`timescale 1ns/1ns
`default_nettype none

module pmes_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [9:0] spr_num,
   input wire logic spr_wr,
   input wire logic spr_rd,
   input wire logic spr_supervisor,
   input wire logic [63:0] spr_wdata,
   input wire logic [31:0] event_src_4,
   input wire logic [31:0] event_src_5,
   input wire logic [31:0] event_src_6,
   input wire logic [31:0] event_src_7,
   input wire logic [15:0] event_src_8,
   input wire logic [4:0] chain_in,
   input wire logic external_interrupt_enable_bit,
   input wire logic external_interrupt_pending,
   input wire logic pm_interrupt,
   input wire logic threshold_cause,
   input wire logic [63:0] threshold_insn_addr,
   input wire logic [63:0] last_completed_addr,
   output logic [4:0] count_pulse,
   output logic [4:0] select_valid,
   output logic [63:0] spr_rdata,
   output logic spr_ack,
   output logic spr_priv_fault,
   output logic [31:0] monitor_event_select_1,
   output logic [63:0] sampled_instruction_address
);
   import pmes_pkg::*;

   logic [4:0] sel_4;
   logic [4:0] sel_5;
   logic [4:0] sel_6;
   logic [4:0] sel_7;
   logic [3:0] sel_8;
   logic [4:0] next_hit;
   logic [4:0] next_known;
   logic hit_map_sa;
   logic hit_map_es;
   logic access;
   logic allowed;
   logic wr_es;
   logic wr_sa;
   logic rd_es;
   logic rd_sa;
   logic ee_off_pending;

   // Field extraction
   assign sel_4 = monitor_event_select_1[PMES_SEL4_LSB +: PMES_SEL_W];
   assign sel_5 = monitor_event_select_1[PMES_SEL5_LSB +: PMES_SEL_W];
   assign sel_6 = monitor_event_select_1[PMES_SEL6_LSB +: PMES_SEL_W];
   assign sel_7 = monitor_event_select_1[PMES_SEL7_LSB +: PMES_SEL_W];
   assign sel_8 = monitor_event_select_1[PMES_SEL8_LSB +: PMES_SEL8_W];

   assign ee_off_pending = !external_interrupt_enable_bit &&
      external_interrupt_pending;

   // Counter 4 routing
   always_comb begin
      next_hit[0] = 1'b0;
      next_known[0] = 1'b1;
      unique case (sel_4)
         5'h00,
         5'h01,
         5'h02,
         5'h03,
         5'h04,
         5'h05,
         5'h07,
         5'h08,
         5'h09,
         5'h0A,
         5'h0B,
         5'h0C,
         5'h0D,
         5'h0E,
         5'h10,
         5'h11,
         5'h12,
         5'h13,
         5'h14,
         5'h16: begin
            next_hit[0] = event_src_4[sel_4];
         end
         PMES_C4_DISPATCH_EMPTY,
         PMES_C4_LINK_STACK_ERR,
         PMES_C4_CR_LOGIC_RESULT: begin
            next_hit[0] = event_src_4[sel_4];
         end
         PMES_C4_SNOOP_CLEAN_L1: begin
            next_hit[0] = event_src_4[sel_4];
         end
         PMES_CODE_CHAIN: begin
            next_hit[0] = chain_in[0];
         end
         default: begin
            next_known[0] = 1'b0;
         end
      endcase
   end

   // Counter 5 routing
   always_comb begin
      next_hit[1] = 1'b0;
      next_known[1] = 1'b1;
      unique case (sel_5)
         PMES_C5_DATA_XLATE_MISS,
         PMES_C5_FETCH_BLOCK,
         PMES_C5_NONE_COMPLETED: begin
            next_hit[1] = event_src_5[sel_5];
         end
         5'h04,
         5'h05,
         5'h06,
         5'h07,
         5'h08,
         5'h09,
         5'h0B,
         5'h0C: begin
            next_hit[1] = event_src_5[sel_5];
         end
         PMES_C5_SNOOP_M_TO_I,
         PMES_C5_RETRY_IN: begin
            next_hit[1] = event_src_5[sel_5];
         end
         PMES_CODE_CHAIN: begin
            next_hit[1] = chain_in[1];
         end
         default: begin
            next_known[1] = 1'b0;
         end
      endcase
   end

   // Counter 6 routing
   always_comb begin
      next_hit[2] = 1'b0;
      next_known[2] = 1'b1;
      unique case (sel_6)
         5'h02,
         5'h03,
         5'h04,
         5'h05,
         5'h06,
         5'h08,
         5'h0A,
         5'h0B,
         5'h0C,
         5'h0D: begin
            next_hit[2] = event_src_6[sel_6];
         end
         PMES_C6_STORE_HIT_L1,
         PMES_C6_SNOOP_E_TO_S: begin
            next_hit[2] = event_src_6[sel_6];
         end
         PMES_C6_EE_OFF_PENDING: begin
            // Built here so every cycle of the condition counts
            next_hit[2] = ee_off_pending;
         end
         PMES_CODE_CHAIN: begin
            next_hit[2] = chain_in[2];
         end
         default: begin
            next_known[2] = 1'b0;
         end
      endcase
   end

   // Counter 7 routing
   always_comb begin
      next_hit[3] = 1'b0;
      next_known[3] = 1'b1;
      unique case (sel_7)
         PMES_C7_ICACHE_MISS,
         PMES_C7_BRANCH_CANCEL: begin
            next_hit[3] = event_src_7[sel_7];
         end
         5'h01,
         5'h02,
         5'h04,
         5'h06,
         5'h07,
         5'h0A,
         5'h0B: begin
            next_hit[3] = event_src_7[sel_7];
         end
         PMES_CODE_CHAIN: begin
            next_hit[3] = chain_in[3];
         end
         default: begin
            next_known[3] = 1'b0;
         end
      endcase
   end

   // Counter 8 routing, narrower field
   always_comb begin
      next_hit[4] = 1'b0;
      next_known[4] = 1'b1;
      unique case (sel_8)
         PMES_C8_STCX_OK,
         PMES_C8_RETRY_OUT: begin
            next_hit[4] = event_src_8[sel_8];
         end
         4'h1,
         4'h2,
         4'h4,
         4'h7,
         4'h8,
         4'hA,
         4'hB,
         4'hC: begin
            next_hit[4] = event_src_8[sel_8];
         end
         PMES_CODE8_CHAIN: begin
            next_hit[4] = chain_in[4];
         end
         default: begin
            next_known[4] = 1'b0;
         end
      endcase
   end

   // Registered event pulses, one per counter
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_cnt
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               count_pulse[g] <= 1'b0;
            end else if (clk_en) begin
               count_pulse[g] <= next_hit[g] && next_known[g];
            end
         end

         always_ff @(posedge clk) begin
            if (!reset_n) begin
               select_valid[g] <= 1'b0;
            end else if (clk_en) begin
               select_valid[g] <= next_known[g];
            end
         end
      end
   endgenerate

   // Special register access decode
   assign hit_map_sa = (spr_num == PMES_SPR_SAMPLED_ADDR);
   assign hit_map_es = (spr_num == PMES_SPR_EVENT_SEL_1);
   assign access = (spr_wr || spr_rd) && (hit_map_sa || hit_map_es);
   // Problem-state software gets a fault, never the data
   assign allowed = access && spr_supervisor;

   // Qualified strobes, so a refused access never reaches a register
   assign wr_es = allowed && spr_wr && hit_map_es;
   assign wr_sa = allowed && spr_wr && hit_map_sa;
   assign rd_es = allowed && spr_rd && hit_map_es;
   assign rd_sa = allowed && spr_rd && hit_map_sa;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         monitor_event_select_1 <= PMES_EVENT_SEL_RESET;
      end else if (clk_en) begin
         if (wr_es) begin
            monitor_event_select_1 <= spr_wdata[31:0];
         end
      end
   end

   // A capture in the same cycle as a write wins: the sample is the
   // fresher information and software can always write again
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sampled_instruction_address <= PMES_SAMPLED_RESET;
      end else if (clk_en) begin
         if (pm_interrupt) begin
            if (threshold_cause) begin
               sampled_instruction_address <= threshold_insn_addr;
            end else begin
               sampled_instruction_address <= last_completed_addr;
            end
         end else if (wr_sa) begin
            sampled_instruction_address <= spr_wdata;
         end
      end
   end

   // Read data, acknowledge and privilege fault
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         spr_ack <= 1'b0;
      end else if (clk_en) begin
         spr_ack <= allowed;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         spr_priv_fault <= 1'b0;
      end else if (clk_en) begin
         spr_priv_fault <= access && !spr_supervisor;
      end
   end

   // Read data falls back to zero so a refused read leaks nothing
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         spr_rdata <= 64'h0000_0000_0000_0000;
      end else if (clk_en) begin
         if (rd_sa) begin
            spr_rdata <= sampled_instruction_address;
         end else if (rd_es) begin
            spr_rdata <= {32'h0000_0000, monitor_event_select_1};
         end else begin
            spr_rdata <= 64'h0000_0000_0000_0000;
         end
      end
   end

endmodule

`default_nettype wire

// [test/pmes_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module pmes_checker
   import pmes_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [9:0] spr_num,
   input wire logic spr_wr,
   input wire logic spr_rd,
   input wire logic spr_supervisor,
   input wire logic [4:0] chain_in,
   input wire logic external_interrupt_enable_bit,
   input wire logic external_interrupt_pending,
   input wire logic pm_interrupt,
   input wire logic threshold_cause,
   input wire logic [63:0] threshold_insn_addr,
   input wire logic [63:0] last_completed_addr,
   input wire logic [4:0] count_pulse,
   input wire logic [63:0] spr_rdata,
   input wire logic spr_ack,
   input wire logic spr_priv_fault,
   input wire logic [31:0] monitor_event_select_1,
   input wire logic [63:0] sampled_instruction_address
);
   wire logic acc = clk_en && (spr_wr || spr_rd);
   wire logic map = spr_num == PMES_SPR_SAMPLED_ADDR ||
      spr_num == PMES_SPR_EVENT_SEL_1;
   wire logic [31:0] s = monitor_event_select_1;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_ack;
      acc && map && spr_supervisor |=> spr_ack && !spr_priv_fault;
   endproperty
   a_ack: assert property (p_ack) else $error("access not taken");
   property p_fault;
      acc && map && !spr_supervisor |=> spr_priv_fault && spr_rdata == '0;
   endproperty
   a_fault: assert property (p_fault) else $error("no fault");
   property p_thr;
      clk_en && pm_interrupt && threshold_cause
         |=> sampled_instruction_address == $past(threshold_insn_addr);
   endproperty
   a_thr: assert property (p_thr) else $error("bad capture");
   property p_last;
      clk_en && pm_interrupt && !threshold_cause
         |=> sampled_instruction_address == $past(last_completed_addr);
   endproperty
   a_last: assert property (p_last) else $error("bad capture");
   // Software writes to the sampled register are the only other writer
   property p_hold;
      clk_en && !pm_interrupt && !(spr_wr && spr_num == PMES_SPR_SAMPLED_ADDR)
         |=> $stable(sampled_instruction_address);
   endproperty
   a_hold: assert property (p_hold) else $error("capture moved");
   property p_chain5;
      clk_en && s[21:17] == 5'h0F |=> count_pulse[1] == $past(chain_in[1]);
   endproperty
   a_chain5: assert property (p_chain5) else $error("chain 5");
   property p_chain8;
      clk_en && s[6:3] == 4'hF |=> count_pulse[4] == $past(chain_in[4]);
   endproperty
   a_chain8: assert property (p_chain8) else $error("chain 8");
   property p_pend6;
      clk_en && s[16:12] == 5'h09 |=> count_pulse[2] ==
         $past(!external_interrupt_enable_bit && external_interrupt_pending);
   endproperty
   a_pend6: assert property (p_pend6) else $error("pending 6");
   property p_freeze;
      !clk_en |=> $stable(monitor_event_select_1) &&
         $stable(sampled_instruction_address) && $stable(spr_ack);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved");
endmodule
`default_nettype wire

// [test/pmes_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
module pmes_top_test;
   import pmes_pkg::*;
   // Assigned codes per counter; anything else must stay silent
   localparam logic [31:0] valid_map [5] = '{32'h0BDF_FFBF, 32'h0000_BFF7,
      32'h0000_FF7E, 32'h0000_8CDF, 32'h0000_9DBE};
   localparam logic [23:0] corner [6] = '{{5'h17, 5'h00, 5'h09, 5'h00, 4'h5},
      {5'h18, 5'h01, 5'h0E, 5'h03, 4'h3}, {5'h19, 5'h02, 5'h01, 5'h0F, 4'hF},
      {5'h1B, 5'h0D, 5'h0F, 5'h1F, 4'h0}, {5'h0F, 5'h0A, 5'h00, 5'h05, 4'h6},
      {5'h1A, 5'h0F, 5'h07, 5'h0F, 4'hF}};
   logic clk = 1'h0, reset_n = 1'h0, spr_wr = 1'h0, spr_rd = 1'h0;
   logic spr_supervisor = 1'h0, int_en = 1'h0, int_pend = 1'h0;
   logic pm_interrupt = 1'h0, threshold_cause = 1'h0, clk_en = 1'h1;
   logic [9:0] spr_num = 10'h000;
   logic [63:0] spr_wdata = '0, threshold_insn_addr = '0;
   logic [63:0] last_completed_addr = '0;
   logic [31:0] event_src_4 = '0, event_src_5 = '0, event_src_6 = '0;
   logic [31:0] event_src_7 = '0, sel_reg = '0, seed = 32'hE132;
   logic [15:0] event_src_8 = '0;
   logic [4:0] chain_in = '0, count_pulse, select_valid;
   logic [63:0] spr_rdata, sampled;
   logic [31:0] sel_out;
   logic spr_ack, spr_priv_fault;
   int n_fail = 0, checks = 0;
   pmes_top u_dut (.clk, .reset_n, .clk_en, .spr_num, .spr_wr, .spr_rd,
      .spr_supervisor, .spr_wdata, .event_src_4, .event_src_5, .event_src_6,
      .event_src_7, .event_src_8, .chain_in,
      .external_interrupt_enable_bit(int_en),
      .external_interrupt_pending(int_pend), .pm_interrupt, .threshold_cause,
      .threshold_insn_addr, .last_completed_addr, .count_pulse, .select_valid,
      .spr_rdata, .spr_ack, .spr_priv_fault, .monitor_event_select_1(sel_out),
      .sampled_instruction_address(sampled));
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] expect_ev();
      logic [4:0] c;
      logic [31:0] s;
      logic [9:0] e;
      for (int k = 0; k < 5; k++) begin
         c = k == 4 ? {1'h0, sel_reg[6:3]} : sel_reg[26 - 5 * k -: 5];
         s = k == 0 ? event_src_4 : k == 1 ? event_src_5 : k == 2 ?
            event_src_6 : k == 3 ? event_src_7 : {16'h0000, event_src_8};
         e[k + 5] = valid_map[k][c];
         if (c == 5'h0F) e[k] = chain_in[k];
         else if (k == 2 && c == 5'h09) e[k] = !int_en && int_pend;
         else e[k] = valid_map[k][c] && s[c];
      end
      return e;
   endfunction
   task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Answer is {ack, fault, rdata} just after the clock edge that takes the request
   task automatic special_register(input logic wr, input logic [9:0] num, input logic s,
         input logic [63:0] d, input logic [65:0] e);
      @(posedge clk);
      spr_wr <= wr;
      spr_rd <= !wr;
      spr_num <= num;
      spr_supervisor <= s;
      spr_wdata <= d;
      @(posedge clk);
      spr_wr <= 1'h0;
      spr_rd <= 1'h0;
      #1;
      cmp({62'h0, spr_ack, spr_priv_fault, spr_rdata}, {62'h0, e});
   endtask
   task automatic run(input int n);
      logic [9:0] e;
      logic [31:0] r;
      repeat (n) begin
         @(posedge clk);
         e = expect_ev();
         event_src_4 <= rnd();
         event_src_5 <= rnd();
         event_src_6 <= rnd();
         event_src_7 <= rnd();
         r = rnd();
         event_src_8 <= r[15:0];
         chain_in <= r[20:16];
         int_en <= r[21];
         int_pend <= r[22];
         #1;
         cmp({118'h0, select_valid, count_pulse}, {118'h0, e});
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end
   initial begin
      logic [63:0] d;
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      #1;
      cmp({32'h0, sel_out, sampled}, 128'h0);
      run(8);
      $display("test reset done");
      special_register(1'h0, 10'h31F, 1'h1, '0, '0);
      special_register(1'h1, 10'h31E, 1'h0, '1, {2'h1, 64'h0});
      special_register(1'h0, 10'h31E, 1'h1, '0, {2'h2, 64'h0});
      d = {rnd(), rnd()};
      special_register(1'h1, 10'h30C, 1'h1, d, {2'h2, 64'h0});
      special_register(1'h0, 10'h30C, 1'h0, '0, {2'h1, 64'h0});
      special_register(1'h0, 10'h30C, 1'h1, '0, {2'h2, d});
      $display("test register access done");
      for (int t = 0; t < 2; t++) begin
         @(posedge clk);
         d = {rnd(), rnd()};
         pm_interrupt <= 1'h1;
         threshold_cause <= t[0];
         threshold_insn_addr <= d;
         last_completed_addr <= ~d;
         @(posedge clk);
         pm_interrupt <= 1'h0;
         #1;
         cmp({64'h0, sampled}, {64'h0, t[0] ? d : ~d});
      end
      // Frozen clock enable: a write must neither land nor be answered
      @(posedge clk);
      clk_en <= 1'h0;
      special_register(1'h1, 10'h30C, 1'h1, ~d, '0);
      cmp({64'h0, sampled}, {64'h0, d});
      clk_en <= 1'h1;
      $display("test capture done");
      for (int i = 0; i < 30; i++) begin
         d = {32'h0, rnd()};
         sel_reg = {5'h00, i < 6 ? corner[i] : d[23:0], 3'h0};
         special_register(1'h1, 10'h31E, 1'h1, {32'h0, sel_reg}, {2'h2, 64'h0});
         cmp({96'h0, sel_out}, {96'h0, sel_reg});
         run(6);
      end
      $display("test event select done");
      give_verdict();
   end
endmodule
bind pmes_top pmes_checker u_chk (.*);
`default_nettype wire
